// File: design/pcs_pkg.sv
// Package: register map, field positions and reset values of the peripheral clock selector
package pcs_pkg;
	localparam int PCS_ADDR_W = 12;
	localparam int PCS_NUM_CFG = 11;
	localparam int PCS_NUM_FRAC = 3;

	// Masked configuration register offsets (byte addresses)
	localparam logic [11:0] PCS_OFS_SDIO_OUT  = 12'h14C;
	localparam logic [11:0] PCS_OFS_EMMC_SRC  = 12'h150;
	localparam logic [11:0] PCS_OFS_EMMC_OUT  = 12'h154;
	localparam logic [11:0] PCS_OFS_ETH_FLASH = 12'h158;
	localparam logic [11:0] PCS_OFS_BUS_ETH   = 12'h15C;
	localparam logic [11:0] PCS_OFS_BUS_LOW   = 12'h160;
	localparam logic [11:0] PCS_OFS_CIPHER    = 12'h164;
	localparam logic [11:0] PCS_OFS_PDM_CFG   = 12'h168;
	localparam logic [11:0] PCS_OFS_I2S0_CFG  = 12'h170;
	localparam logic [11:0] PCS_OFS_I2S1_CFG  = 12'h178;
	localparam logic [11:0] PCS_OFS_I2S2_CFG  = 12'h180;
	// Full-word fractional divider offsets
	localparam logic [11:0] PCS_OFS_PDM_FRAC  = 12'h16C;
	localparam logic [11:0] PCS_OFS_I2S0_FRAC = 12'h174;
	localparam logic [11:0] PCS_OFS_I2S1_FRAC = 12'h17C;

	// Lower-half reset values, and the full-word reset value of the fractional dividers
	localparam logic [15:0] PCS_RST_SDIO_OUT  = 16'h0002;
	localparam logic [15:0] PCS_RST_EMMC_SRC  = 16'h0002;
	localparam logic [15:0] PCS_RST_EMMC_OUT  = 16'h0002;
	localparam logic [15:0] PCS_RST_ETH_FLASH = 16'h170B;
	localparam logic [15:0] PCS_RST_BUS_ETH   = 16'h0581;
	localparam logic [15:0] PCS_RST_BUS_LOW   = 16'h0107;
	localparam logic [15:0] PCS_RST_CIPHER    = 16'h0305;
	localparam logic [15:0] PCS_RST_DIV7      = 16'h000B;
	localparam logic [31:0] PCS_RST_FRAC      = 32'h0BB8EA60;

	// Writable bits of each lower half; reserved bits stay zero
	localparam logic [15:0] PCS_WM_OUT_DIV8  = 16'h80FF;
	localparam logic [15:0] PCS_WM_EMMC_SRC  = 16'hC0FF;
	localparam logic [15:0] PCS_WM_ETH_FLASH = 16'hDFFF;
	localparam logic [15:0] PCS_WM_BUS_ETH   = 16'h9FCF;
	localparam logic [15:0] PCS_WM_BUS_LOW   = 16'h031F;
	localparam logic [15:0] PCS_WM_CIPHER    = 16'hDFDF;
	localparam logic [15:0] PCS_WM_PDM_CFG   = 16'h837F;
	localparam logic [15:0] PCS_WM_I2S0_CFG  = 16'hDD7F;
	localparam logic [15:0] PCS_WM_I2S_CFG   = 16'h8D7F;

	// Register indices into the tables below
	localparam int PCS_I_SDIO = 0;
	localparam int PCS_I_EMMC_SRC = 1;
	localparam int PCS_I_EMMC_OUT = 2;
	localparam int PCS_I_ETH_FLASH = 3;
	localparam int PCS_I_BUS_ETH = 4;
	localparam int PCS_I_BUS_LOW = 5;
	localparam int PCS_I_CIPHER = 6;
	localparam int PCS_I_PDM = 7;
	localparam int PCS_I_I2S0 = 8;
	localparam int PCS_I_I2S1 = 9;
	localparam int PCS_I_I2S2 = 10;

	localparam logic [11:0] PCS_CFG_OFS [PCS_NUM_CFG] = '{PCS_OFS_SDIO_OUT, PCS_OFS_EMMC_SRC,
		PCS_OFS_EMMC_OUT, PCS_OFS_ETH_FLASH, PCS_OFS_BUS_ETH, PCS_OFS_BUS_LOW, PCS_OFS_CIPHER,
		PCS_OFS_PDM_CFG, PCS_OFS_I2S0_CFG, PCS_OFS_I2S1_CFG, PCS_OFS_I2S2_CFG};
	localparam logic [15:0] PCS_CFG_RST [PCS_NUM_CFG] = '{PCS_RST_SDIO_OUT, PCS_RST_EMMC_SRC,
		PCS_RST_EMMC_OUT, PCS_RST_ETH_FLASH, PCS_RST_BUS_ETH, PCS_RST_BUS_LOW, PCS_RST_CIPHER,
		PCS_RST_DIV7, PCS_RST_DIV7, PCS_RST_DIV7, PCS_RST_DIV7};
	localparam logic [15:0] PCS_CFG_WM [PCS_NUM_CFG] = '{PCS_WM_OUT_DIV8, PCS_WM_EMMC_SRC,
		PCS_WM_OUT_DIV8, PCS_WM_ETH_FLASH, PCS_WM_BUS_ETH, PCS_WM_BUS_LOW, PCS_WM_CIPHER,
		PCS_WM_PDM_CFG, PCS_WM_I2S0_CFG, PCS_WM_I2S_CFG, PCS_WM_I2S_CFG};
	localparam logic [11:0] PCS_FRAC_OFS [PCS_NUM_FRAC] = '{PCS_OFS_PDM_FRAC, PCS_OFS_I2S0_FRAC,
		PCS_OFS_I2S1_FRAC};

	// Field positions
	localparam int PCS_OUT_SEL_BIT = 15;
	localparam int PCS_SRC2_LSB = 14;
	localparam int PCS_HI_DIV_LSB = 8;
	localparam int PCS_LO_SEL_BIT = 7;
	localparam int PCS_LO_SEL2_LSB = 6;
	localparam int PCS_RMII_EXT_BIT = 6;
	localparam int PCS_PDM_SRC_LSB = 8;
	localparam int PCS_I2S_SEL_LSB = 10;
	localparam int PCS_I2S_DIR_BIT = 12;
	localparam int PCS_I2S_PLL_BIT = 8;
	localparam int PCS_FRAC_NUM_LSB = 16;

	// Register bus request
	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [PCS_ADDR_W-1:0] addr;
		logic [31:0]           wdata;
	} pcs_bus_req_type;
endpackage

// File: design/pcs_clock_unit.sv
// Peripheral clock selector: register file, glitch-free muxes, integer and fractional dividers
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Even-duty integer divider: toggles every div+1 source edges, so odd values stay 50%
module pcs_clock_divider #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         src,
	input  wire logic [W-1:0] div,
	output var  logic         clk_out
);
	logic         src_q;
	logic [W-1:0] count;

	// Source edge history
	always_ff @(posedge clk) begin
		if (!resetn) begin
			src_q <= 1'b0;
		end else begin
			src_q <= src;
		end
	end

	// Count both edges; >= copes with a divider shrunk mid-count
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= '0;
			clk_out <= 1'b0;
		end else if (src != src_q) begin
			if (count >= div) begin
				count <= '0;
				clk_out <= ~clk_out;
			end else begin
				count <= count + 1'b1;
			end
		end
	end
endmodule // pcs_clock_divider

// Source mux that only switches while both old output and new source are low
module pcs_glitch_free_mux (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [3:0] src,
	input  wire logic [1:0] sel,
	output var  logic       clk_out
);
	logic [1:0] cur_sel;

	// no runt pulses
	// A stopped-high old source delays the switch until it falls
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cur_sel <= 2'h0;
			clk_out <= 1'b0;
		end else if (sel != cur_sel && !clk_out && !src[sel]) begin
			cur_sel <= sel;
			clk_out <= 1'b0;
		end else begin
			clk_out <= src[cur_sel];
		end
	end
endmodule // pcs_glitch_free_mux

// Fractional divider: passes num of every den input periods
module pcs_frac_divider (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        src,
	input  wire logic [15:0] num,
	input  wire logic [15:0] den,
	output var  logic        clk_out
);
	logic        src_q;
	logic        fire;
	logic [16:0] acc;
	logic [16:0] sum;
	logic        next_fire;
	logic        rise;

	// Accumulator step; a zero denominator gives no clock
	always_comb begin
		rise = src && !src_q;
		sum = acc + {1'b0, num};
		next_fire = (den != 16'h0000) && (sum >= {1'b0, den});
	end

	// out equals in times num over den
	always_ff @(posedge clk) begin
		if (!resetn) begin
			src_q <= 1'b0;
			acc <= 17'h00000;
			fire <= 1'b0;
		end else begin
			src_q <= src;
			if (rise) begin
				fire <= next_fire;
				acc <= next_fire ? sum - {1'b0, den} : sum;
			end
		end
	end

	// Gate whole input high phases, never part of one
	always_ff @(posedge clk) begin
		if (!resetn) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= src && (rise ? next_fire : fire);
		end
	end
endmodule // pcs_frac_divider

module pcs_clock_unit
	import pcs_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire pcs_bus_req_type bus_req,
	output var  logic [31:0]     rdata,
	input  wire logic            general_purpose_pll_source,
	input  wire logic            codec_pll_source,
	input  wire logic            third_pll_source,
	input  wire logic            crystal_oscillator_input,
	input  wire logic            sdio_card_clock,
	input  wire logic            peripheral_axi_clock,
	input  wire logic            i2s0_receive_clock,
	input  wire logic            i2s2_fraction_clock,
	input  wire logic            i2s0_transmit_master_input,
	input  wire logic            i2s1_master_input,
	input  wire logic            i2s2_master_input,
	input  wire logic            ethernet_phy_reference,
	output var  logic            sdio_output_clock,
	output var  logic            emmc_clock,
	output var  logic            ethernet_mac_clock,
	output var  logic            rmii_speed_100,
	output var  logic            serial_flash_clock,
	output var  logic            bus_axi_clock,
	output var  logic            bus_ahb_clock,
	output var  logic            bus_apb_clock,
	output var  logic            ethernet_apb_clock,
	output var  logic            cipher_asym_clock,
	output var  logic            cipher_core_clock,
	output var  logic            pdm_clock,
	output var  logic            halved_crystal_clock,
	output var  logic            i2s0_transmit_clock,
	output var  logic            i2s0_master_clock,
	output var  logic            i2s1_clock,
	output var  logic            i2s1_master_clock,
	output var  logic            i2s2_clock,
	output var  logic            i2s2_master_clock
);
	logic [15:0] cfg [PCS_NUM_CFG];
	logic [31:0] frac [PCS_NUM_FRAC];
	logic [15:0] wr_mask;
	logic [31:0] next_rdata;
	logic [3:0]  pin_meta;
	logic [3:0]  pin_sync;
	logic [3:0]  pll4;
	logic        emmc_src, emmc_div, emmc_even, sdio_even;
	logic        mac_src, mac_div, flash_src, bus_src;
	logic        asym_src, core_src, pdm_src, pdm_div, pdm_frac;
	logic        i2s0_src, i2s0_div, i2s0_frac, i2s0_dir;
	logic        i2s1_src, i2s1_div, i2s1_frac, i2s2_src, i2s2_div;

	assign pll4 = {crystal_oscillator_input, third_pll_source, codec_pll_source, general_purpose_pll_source};
	assign wr_mask = bus_req.wdata[31:16];

	// Pins come from other clock domains: two flops before use
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {ethernet_phy_reference, i2s2_master_input, i2s1_master_input, i2s0_transmit_master_input};
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < PCS_NUM_CFG; i++) begin
				cfg[i] <= PCS_CFG_RST[i];
			end
		end else if (bus_req.wr) begin
			for (int i = 0; i < PCS_NUM_CFG; i++) begin
				if (bus_req.addr == PCS_CFG_OFS[i]) begin
					cfg[i] <= (cfg[i] & ~(wr_mask & PCS_CFG_WM[i]))
						| (bus_req.wdata[15:0] & wr_mask & PCS_CFG_WM[i]);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < PCS_NUM_FRAC; i++) begin
				frac[i] <= PCS_RST_FRAC;
			end
		end else if (bus_req.wr) begin
			for (int i = 0; i < PCS_NUM_FRAC; i++) begin
				if (bus_req.addr == PCS_FRAC_OFS[i]) begin
					frac[i] <= bus_req.wdata;
				end
			end
		end
	end

	// mask half reads zero
	// Unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h00000000;
		for (int i = 0; i < PCS_NUM_CFG; i++) begin
			if (bus_req.addr == PCS_CFG_OFS[i]) begin
				next_rdata = {16'h0000, cfg[i]};
			end
		end
		for (int i = 0; i < PCS_NUM_FRAC; i++) begin
			if (bus_req.addr == PCS_FRAC_OFS[i]) begin
				next_rdata = frac[i];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= bus_req.rd ? next_rdata : 32'h00000000;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rmii_speed_100 <= PCS_RST_BUS_ETH[PCS_LO_SEL_BIT];
		end else begin
			rmii_speed_100 <= cfg[PCS_I_BUS_ETH][PCS_LO_SEL_BIT];
		end
	end

	pcs_clock_divider #(.W(8)) u_sdio_even (.clk(clk), .resetn(resetn), .src(sdio_card_clock),
		.div(cfg[PCS_I_SDIO][7:0]), .clk_out(sdio_even));
	pcs_glitch_free_mux u_sdio_out (.clk(clk), .resetn(resetn), .src({2'b00, sdio_even, sdio_card_clock}),
		.sel({1'b0, cfg[PCS_I_SDIO][PCS_OUT_SEL_BIT]}), .clk_out(sdio_output_clock));

	pcs_glitch_free_mux u_emmc_src (.clk(clk), .resetn(resetn), .src(pll4),
		.sel(cfg[PCS_I_EMMC_SRC][PCS_SRC2_LSB +: 2]), .clk_out(emmc_src));
	pcs_clock_divider #(.W(8)) u_emmc_div (.clk(clk), .resetn(resetn), .src(emmc_src),
		.div(cfg[PCS_I_EMMC_SRC][7:0]), .clk_out(emmc_div));
	pcs_clock_divider #(.W(8)) u_emmc_even (.clk(clk), .resetn(resetn), .src(emmc_div),
		.div(cfg[PCS_I_EMMC_OUT][7:0]), .clk_out(emmc_even));
	pcs_glitch_free_mux u_emmc_out (.clk(clk), .resetn(resetn), .src({2'b00, emmc_even, emmc_div}),
		.sel({1'b0, cfg[PCS_I_EMMC_OUT][PCS_OUT_SEL_BIT]}), .clk_out(emmc_clock));

	// MAC source and divider
	// Encoding 3 is unused and yields a stopped clock
	pcs_glitch_free_mux u_mac_src (.clk(clk), .resetn(resetn), .src({1'b0, pll4[2:0]}),
		.sel(cfg[PCS_I_ETH_FLASH][PCS_SRC2_LSB +: 2]), .clk_out(mac_src));
	pcs_clock_divider #(.W(5)) u_mac_div (.clk(clk), .resetn(resetn), .src(mac_src),
		.div(cfg[PCS_I_ETH_FLASH][PCS_HI_DIV_LSB +: 5]), .clk_out(mac_div));
	pcs_glitch_free_mux u_mac_out (.clk(clk), .resetn(resetn), .src({2'b00, pin_sync[3], mac_div}),
		.sel({1'b0, cfg[PCS_I_BUS_ETH][PCS_RMII_EXT_BIT]}), .clk_out(ethernet_mac_clock));

	pcs_glitch_free_mux u_flash_src (.clk(clk), .resetn(resetn), .src({2'b00, pll4[1:0]}),
		.sel({1'b0, cfg[PCS_I_ETH_FLASH][PCS_LO_SEL_BIT]}), .clk_out(flash_src));
	pcs_clock_divider #(.W(7)) u_flash_div (.clk(clk), .resetn(resetn), .src(flash_src),
		.div(cfg[PCS_I_ETH_FLASH][6:0]), .clk_out(serial_flash_clock));

	pcs_glitch_free_mux u_bus_src (.clk(clk), .resetn(resetn), .src({2'b00, pll4[1:0]}),
		.sel({1'b0, cfg[PCS_I_BUS_ETH][PCS_OUT_SEL_BIT]}), .clk_out(bus_src));
	pcs_clock_divider #(.W(5)) u_axi_div (.clk(clk), .resetn(resetn), .src(bus_src),
		.div(cfg[PCS_I_BUS_ETH][PCS_HI_DIV_LSB +: 5]), .clk_out(bus_axi_clock));

	pcs_clock_divider #(.W(5)) u_ahb_div (.clk(clk), .resetn(resetn), .src(bus_src),
		.div(cfg[PCS_I_BUS_LOW][4:0]), .clk_out(bus_ahb_clock));
	pcs_clock_divider #(.W(2)) u_apb_div (.clk(clk), .resetn(resetn), .src(bus_axi_clock),
		.div(cfg[PCS_I_BUS_LOW][PCS_HI_DIV_LSB +: 2]), .clk_out(bus_apb_clock));

	pcs_clock_divider #(.W(4)) u_eapb_div (.clk(clk), .resetn(resetn), .src(peripheral_axi_clock),
		.div(cfg[PCS_I_BUS_ETH][3:0]), .clk_out(ethernet_apb_clock));

	pcs_glitch_free_mux u_asym_src (.clk(clk), .resetn(resetn), .src({1'b0, pll4[2:0]}),
		.sel(cfg[PCS_I_CIPHER][PCS_SRC2_LSB +: 2]), .clk_out(asym_src));
	pcs_clock_divider #(.W(5)) u_asym_div (.clk(clk), .resetn(resetn), .src(asym_src),
		.div(cfg[PCS_I_CIPHER][PCS_HI_DIV_LSB +: 5]), .clk_out(cipher_asym_clock));
	pcs_glitch_free_mux u_core_src (.clk(clk), .resetn(resetn), .src({1'b0, pll4[2:0]}),
		.sel(cfg[PCS_I_CIPHER][PCS_LO_SEL2_LSB +: 2]), .clk_out(core_src));
	pcs_clock_divider #(.W(5)) u_core_div (.clk(clk), .resetn(resetn), .src(core_src),
		.div(cfg[PCS_I_CIPHER][4:0]), .clk_out(cipher_core_clock));

	pcs_glitch_free_mux u_pdm_src (.clk(clk), .resetn(resetn),
		.src({1'b0, third_pll_source, crystal_oscillator_input, general_purpose_pll_source}),
		.sel(cfg[PCS_I_PDM][PCS_PDM_SRC_LSB +: 2]), .clk_out(pdm_src));
	pcs_clock_divider #(.W(7)) u_pdm_div (.clk(clk), .resetn(resetn), .src(pdm_src),
		.div(cfg[PCS_I_PDM][6:0]), .clk_out(pdm_div));
	pcs_frac_divider u_pdm_frac (.clk(clk), .resetn(resetn), .src(pdm_div),
		.num(frac[0][PCS_FRAC_NUM_LSB +: 16]), .den(frac[0][15:0]), .clk_out(pdm_frac));
	pcs_glitch_free_mux u_pdm_out (.clk(clk), .resetn(resetn), .src({2'b00, pdm_frac, pdm_div}),
		.sel({1'b0, cfg[PCS_I_PDM][PCS_OUT_SEL_BIT]}), .clk_out(pdm_clock));

	// Halved crystal: divide value one gives half rate
	pcs_clock_divider #(.W(1)) u_xtal_half (.clk(clk), .resetn(resetn), .src(crystal_oscillator_input),
		.div(1'b1), .clk_out(halved_crystal_clock));

	pcs_glitch_free_mux u_i2s0_src (.clk(clk), .resetn(resetn),
		.src({2'b00, third_pll_source, general_purpose_pll_source}),
		.sel({1'b0, cfg[PCS_I_I2S0][PCS_I2S_PLL_BIT]}), .clk_out(i2s0_src));
	pcs_clock_divider #(.W(7)) u_i2s0_div (.clk(clk), .resetn(resetn), .src(i2s0_src),
		.div(cfg[PCS_I_I2S0][6:0]), .clk_out(i2s0_div));
	pcs_frac_divider u_i2s0_frac (.clk(clk), .resetn(resetn), .src(i2s0_div),
		.num(frac[1][PCS_FRAC_NUM_LSB +: 16]), .den(frac[1][15:0]), .clk_out(i2s0_frac));
	pcs_glitch_free_mux u_i2s0_sel (.clk(clk), .resetn(resetn),
		.src({halved_crystal_clock, pin_sync[0], i2s0_frac, i2s0_div}),
		.sel(cfg[PCS_I_I2S0][PCS_I2S_SEL_LSB +: 2]), .clk_out(i2s0_transmit_clock));
	pcs_glitch_free_mux u_i2s0_dir (.clk(clk), .resetn(resetn),
		.src({2'b00, i2s0_receive_clock, i2s0_transmit_clock}),
		.sel({1'b0, cfg[PCS_I_I2S0][PCS_I2S_DIR_BIT]}), .clk_out(i2s0_dir));
	pcs_glitch_free_mux u_i2s0_mclk (.clk(clk), .resetn(resetn),
		.src({1'b0, i2s0_receive_clock, halved_crystal_clock, i2s0_dir}),
		.sel(cfg[PCS_I_I2S0][PCS_SRC2_LSB +: 2]), .clk_out(i2s0_master_clock));

	pcs_glitch_free_mux u_i2s1_src (.clk(clk), .resetn(resetn),
		.src({2'b00, third_pll_source, general_purpose_pll_source}),
		.sel({1'b0, cfg[PCS_I_I2S1][PCS_I2S_PLL_BIT]}), .clk_out(i2s1_src));
	pcs_clock_divider #(.W(7)) u_i2s1_div (.clk(clk), .resetn(resetn), .src(i2s1_src),
		.div(cfg[PCS_I_I2S1][6:0]), .clk_out(i2s1_div));
	pcs_frac_divider u_i2s1_frac (.clk(clk), .resetn(resetn), .src(i2s1_div),
		.num(frac[2][PCS_FRAC_NUM_LSB +: 16]), .den(frac[2][15:0]), .clk_out(i2s1_frac));
	pcs_glitch_free_mux u_i2s1_sel (.clk(clk), .resetn(resetn),
		.src({halved_crystal_clock, pin_sync[1], i2s1_frac, i2s1_div}),
		.sel(cfg[PCS_I_I2S1][PCS_I2S_SEL_LSB +: 2]), .clk_out(i2s1_clock));
	pcs_glitch_free_mux u_i2s1_mclk (.clk(clk), .resetn(resetn), .src({2'b00, halved_crystal_clock, i2s1_clock}),
		.sel({1'b0, cfg[PCS_I_I2S1][PCS_OUT_SEL_BIT]}), .clk_out(i2s1_master_clock));

	pcs_glitch_free_mux u_i2s2_src (.clk(clk), .resetn(resetn),
		.src({2'b00, third_pll_source, general_purpose_pll_source}),
		.sel({1'b0, cfg[PCS_I_I2S2][PCS_I2S_PLL_BIT]}), .clk_out(i2s2_src));
	pcs_clock_divider #(.W(7)) u_i2s2_div (.clk(clk), .resetn(resetn), .src(i2s2_src),
		.div(cfg[PCS_I_I2S2][6:0]), .clk_out(i2s2_div));
	pcs_glitch_free_mux u_i2s2_sel (.clk(clk), .resetn(resetn),
		.src({halved_crystal_clock, pin_sync[2], i2s2_fraction_clock, i2s2_div}),
		.sel(cfg[PCS_I_I2S2][PCS_I2S_SEL_LSB +: 2]), .clk_out(i2s2_clock));
	pcs_glitch_free_mux u_i2s2_mclk (.clk(clk), .resetn(resetn), .src({2'b00, halved_crystal_clock, i2s2_clock}),
		.sel({1'b0, cfg[PCS_I_I2S2][PCS_OUT_SEL_BIT]}), .clk_out(i2s2_master_clock));
endmodule // pcs_clock_unit

`default_nettype wire

// File: testbench/pcs_clock_unit_chk.sv
// Checker for the clock unit register port
`timescale 1ns/10ps
`default_nettype none
module pcs_clock_unit_chk
	import pcs_pkg::*;
(
	input wire logic            clk,
	input wire logic            resetn,
	input wire pcs_bus_req_type bus_req,
	input wire logic [31:0]     rdata,
	input wire logic            rmii_speed_100,
	input wire logic            bus_axi_clock
);
	logic [11:0] a;
	logic        rd;
	logic        wr;
	logic        cfg;
	logic        frac;
	logic [15:0] wm;
	logic [15:0] wmask;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Writable bits of the addressed config register
	always_comb begin
		cfg = 1'b0;
		wm = 16'h0;
		for (int i = 0; i < PCS_NUM_CFG; i++) if (PCS_CFG_OFS[i] == a) begin
			cfg = 1'b1;
			wm = PCS_CFG_WM[i];
		end
	end
	// Request decode
	assign a = bus_req.addr;
	assign rd = bus_req.rd;
	assign wr = bus_req.wr;
	assign frac = a == PCS_OFS_PDM_FRAC || a == PCS_OFS_I2S0_FRAC || a == PCS_OFS_I2S1_FRAC;
	assign wmask = bus_req.wdata[31:16] & wm;
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data without a read");
	a_unmapped_zero: assert property ($past(rd && !cfg && !frac) |-> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property ($past(rd && cfg) |-> rdata[31:16] == 16'h0)
		else $error("mask half reads nonzero");
	a_reserved_zero: assert property ($past(rd && cfg) |-> (rdata[15:0] & ~$past(wm)) == 16'h0)
		else $error("reserved bit reads nonzero");
	a_frac_word: assert property (wr && frac ##1 rd && a == $past(a) |=> rdata == $past(bus_req.wdata, 2))
		else $error("fraction word not stored whole");
	a_mask_write: assert property (wr && cfg ##1 rd && a == $past(a) |=>
		((rdata[15:0] ^ $past(bus_req.wdata[15:0], 2)) & $past(wmask, 2)) == 16'h0) else $error("unmasked bit lost");
	a_mask_hold: assert property (rd ##1 wr && cfg && a == $past(a) ##1 rd && a == $past(a) |=>
		((rdata[15:0] ^ $past(rdata[15:0], 2)) & ~$past(bus_req.wdata[31:16], 2)) == 16'h0)
		else $error("masked bit changed");
	a_rmii_copy: assert property ($past(rd && a == PCS_OFS_BUS_ETH) |-> rdata[7] == rmii_speed_100)
		else $error("speed output differs from register");
	a_reset_state: assert property ($rose(resetn) |-> rmii_speed_100 && !bus_axi_clock && rdata == 32'h0)
		else $error("outputs wrong after reset");
	c_mask_write: cover property (wr && cfg ##1 rd);
	c_frac_write: cover property (wr && frac ##1 rd);
	c_speed_low: cover property ($fell(rmii_speed_100));
endmodule // pcs_clock_unit_chk
bind pcs_clock_unit pcs_clock_unit_chk pcs_clock_unit_chk_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req),
	.rdata(rdata), .rmii_speed_100(rmii_speed_100), .bus_axi_clock(bus_axi_clock));
`default_nettype wire

// File: testbench/pcs_clock_unit_tb_top.sv
// Testbench: register map, write masks and clock paths of the clock unit
`timescale 1ns/10ps
`default_nettype none
module pcs_clock_unit_tb_top import pcs_pkg::*;;
	logic            clk = 1'b0;
	logic            resetn = 1'b0;
	pcs_bus_req_type bus_req = '0;
	logic [31:0]     rdata;
	logic [7:0]      sc = 8'h00;
	logic            rmii;
	wire  [17:0]     ck;
	logic [17:0]     prev = 18'h00000;
	logic [11:0]     a;
	int              tog [18];
	int              fails = 0;
	int              samples_checked = 0;
	always #2 clk = ~clk;
	// Source clocks as levels toggling on clk edges
	always @(posedge clk) sc <= sc + 8'h01;
	// Toggle counters; edges counted, not frequency, so no phase hazard
	always @(posedge clk) begin
		for (int i = 0; i < 18; i++) if (ck[i] !== prev[i]) tog[i]++;
		prev <= ck;
	end
	pcs_clock_unit pcs_clock_unit_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
		.general_purpose_pll_source(sc[0]), .codec_pll_source(sc[1]), .third_pll_source(sc[2]),
		.crystal_oscillator_input(sc[0]), .sdio_card_clock(sc[1]), .peripheral_axi_clock(sc[1]),
		.i2s0_receive_clock(sc[2]), .i2s2_fraction_clock(sc[3]), .i2s0_transmit_master_input(sc[3]),
		.i2s1_master_input(sc[4]), .i2s2_master_input(sc[2]), .ethernet_phy_reference(sc[1]),
		.sdio_output_clock(ck[0]), .emmc_clock(ck[3]), .ethernet_mac_clock(ck[4]), .rmii_speed_100(rmii),
		.serial_flash_clock(ck[5]), .bus_axi_clock(ck[1]), .bus_ahb_clock(ck[6]), .bus_apb_clock(ck[7]),
		.ethernet_apb_clock(ck[8]), .cipher_asym_clock(ck[9]), .cipher_core_clock(ck[10]), .pdm_clock(ck[11]),
		.halved_crystal_clock(ck[2]), .i2s0_transmit_clock(ck[12]), .i2s0_master_clock(ck[13]),
		.i2s1_clock(ck[14]), .i2s1_master_clock(ck[15]), .i2s2_clock(ck[16]), .i2s2_master_clock(ck[17]));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rng(input string what, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi) begin
			fails++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// One bus cycle; the next call may follow with no gap
	task automatic req(input logic w, input logic r, input logic [11:0] ad, input logic [31:0] d);
		bus_req <= '{w, r, ad, d};
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
		req(1'b0, 1'b1, ad, 32'h0);
		// Data stands in the next cycle; taken at its closing edge so the bus stays free
		fork
			begin
				@(posedge clk);
				check($sformatf("reg %h", ad), exp, rdata);
			end
		join_none
	endtask
	// Settle, then count toggles over n cycles; long settle as a mux waits for both clocks low
	task automatic span(input int n);
		req(1'b0, 1'b0, 12'h0, 32'h0);
		repeat (50) @(posedge clk);
		tog = '{default: 0};
		repeat (n) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#80000;
		fails++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < PCS_NUM_CFG; i++) rd(PCS_CFG_OFS[i], {16'h0, PCS_CFG_RST[i]});
		for (int i = 0; i < PCS_NUM_FRAC; i++) rd(PCS_FRAC_OFS[i], 32'h0BB8_EA60);
		rd(12'h14C, 32'h0000_0002);
		check("rmii_speed_100", 32'h1, {31'h0, rmii});
		$display("test reset_values done");
		for (int i = 0; i < PCS_NUM_CFG; i++) begin
			a = PCS_CFG_OFS[i];
			req(1'b1, 1'b0, a, 32'hFFFF_FFFF);
			rd(a, {16'h0, PCS_CFG_WM[i]});
			req(1'b1, 1'b0, a, 32'h0000_0000);
			rd(a, {16'h0, PCS_CFG_WM[i]});
			req(1'b1, 1'b0, a, 32'hFFFF_0000);
			rd(a, 32'h0);
			req(1'b1, 1'b0, a, 32'h00FF_A5A5);
			rd(a, {16'h0, PCS_CFG_WM[i] & 16'h00A5});
			req(1'b1, 1'b0, a, {16'hFFFF, PCS_CFG_RST[i]});
		end
		$display("test write_masks done");
		for (int i = 0; i < PCS_NUM_FRAC; i++) begin
			req(1'b1, 1'b0, PCS_FRAC_OFS[i], 32'h1234_ABCD);
			rd(PCS_FRAC_OFS[i], 32'h1234_ABCD);
		end
		req(1'b1, 1'b0, 12'h184, 32'hFFFF_FFFF);
		rd(12'h184, 32'h0);
		rd(12'h148, 32'h0);
		$display("test fraction_unmapped done");
		req(1'b1, 1'b0, PCS_OFS_BUS_ETH, 32'h0080_0000);
		span(2);
		check("rmii_speed_100", 32'h0, {31'h0, rmii});
		$display("test speed done");
		span(120);
		rng("halved_crystal_clock", 59, 61, tog[2]);
		rng("bus_axi_clock", 19, 21, tog[1]);
		rng("sdio_output_clock", 59, 61, tog[0]);
		rng("emmc_clock", 39, 41, tog[3]);
		rng("ethernet_mac_clock", 4, 6, tog[4]);
		rng("serial_flash_clock", 9, 11, tog[5]);
		rng("bus_ahb_clock", 14, 16, tog[6]);
		rng("bus_apb_clock", 9, 11, tog[7]);
		rng("ethernet_apb_clock", 29, 31, tog[8]);
		rng("cipher_asym_clock", 29, 31, tog[9]);
		rng("cipher_core_clock", 19, 21, tog[10]);
		rng("pdm_clock", 9, 11, tog[11]);
		rng("i2s0_transmit_clock", 9, 11, tog[12]);
		rng("i2s0_master_clock", 9, 11, tog[13]);
		rng("i2s1_clock", 9, 11, tog[14]);
		rng("i2s1_master_clock", 9, 11, tog[15]);
		rng("i2s2_clock", 9, 11, tog[16]);
		rng("i2s2_master_clock", 9, 11, tog[17]);
		req(1'b1, 1'b0, PCS_OFS_BUS_ETH, 32'h1F00_0000);
		req(1'b1, 1'b0, PCS_OFS_SDIO_OUT, 32'h8000_8000);
		// Zero numerator: the fractional path must pass no pulse at all
		req(1'b1, 1'b0, PCS_OFS_PDM_FRAC, 32'h0000_FFFF);
		req(1'b1, 1'b0, PCS_OFS_PDM_CFG, 32'h8000_8000);
		span(120);
		rng("bus_axi_clock", 119, 121, tog[1]);
		rng("sdio_output_clock", 19, 21, tog[0]);
		rng("pdm_clock", 0, 0, tog[11]);
		$display("test clocks done");
		complete_run;
	end
endmodule // pcs_clock_unit_tb_top
`default_nettype wire
